// ---- src/rx_steer_pkg.sv ----
// constants and types shared by the receive filter and steering block
package rx_steer_pkg;
    localparam int NUM_CHAN = 8;
    localparam int CHAN_W = 3;
    localparam int CNT_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int BYTE_W = 8;
    // frame geometry
    localparam logic [15:0] MIN_FRAME_LEN = 16'h0040;
    localparam logic [15:0] RUNT_FCS_LEN = 16'h0014;
    localparam logic [15:0] FCS_BYTES = 16'h0004;
    localparam logic [15:0] MAX_LEN_RST = 16'h05ee;
    localparam logic [15:0] CNT_SAT = 16'hffff;
    localparam logic [15:0] DA_BYTES = 16'h0006;
    localparam logic [15:0] TYPE_POS_HI = 16'h000c;
    localparam logic [15:0] TYPE_POS_LO = 16'h000d;
    localparam logic [15:0] TCI_POS_HI = 16'h000e;
    localparam logic [15:0] TCI_POS_LO = 16'h000f;
    // field values
    localparam logic [15:0] VLAN_TYPE = 16'h8100;
    localparam logic [15:0] CTRL_TYPE = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
    localparam logic [47:0] PAUSE_DA = 48'h0180c2000001;
    localparam int GROUP_BIT = 40;
    localparam int PRIO_MSB = 15;
    localparam int PRIO_LSB = 13;
    localparam logic [2:0] PRIO_HIGH_MIN = 3'h4;
    localparam int HASH_W = 6;
    localparam logic [31:0] TEARDOWN_PTR = 32'hfffffffc;

    typedef enum logic [2:0] {
        CLS_PROPER,
        CLS_UNDERSIZED,
        CLS_FRAGMENT,
        CLS_OVERSIZED,
        CLS_JABBER,
        CLS_ERRORED
    } frame_class_t;
endpackage

// ---- src/rx_byte_fifo.sv ----
// byte fifo between the receive filter and the dma side
`timescale 1ns/1ps
`default_nettype none
module rx_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // fill side
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    // drain side
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_st_t;

    fifo_st_t st_q, st_d;
    logic push, pop;

    assign wr_ready = (st_q.cnt != (AW+1)'(DEPTH));
    assign rd_valid = (st_q.cnt != '0);
    assign rd_data = st_q.mem[st_q.rp];
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid && rd_ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wp] = wr_data;
            st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + 1'b1;
        end
        if (pop) begin
            st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule // rx_byte_fifo
`default_nettype wire

// ---- src/rx_filter_steer.sv ----
// receive frame filter, channel steering, free buffer and teardown logic
`timescale 1ns/1ps
`default_nettype none
module rx_filter_steer
    import rx_steer_pkg::*;
#(
    parameter int DATA_FIFO_DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // incoming frame bytes
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    input wire logic in_last,
    input wire logic in_code_err,
    input wire logic in_align_err,
    input wire logic in_crc_err,
    // bytes towards dma
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    // per-frame verdict
    output logic res_valid,
    output logic res_accept,
    output logic [CHAN_W-1:0] res_chan,
    output frame_class_t res_class,
    output logic [15:0] res_len,
    output logic [15:0] res_frame_len,
    output logic res_high_prio,
    output logic res_is_bcast,
    output logic pause_detect,
    // steering configuration
    input wire logic rx_dma_enable,
    input wire logic [NUM_CHAN-1:0] rx_chan_enable_set,
    input wire logic [NUM_CHAN-1:0] rx_chan_enable_clear,
    output logic [NUM_CHAN-1:0] chan_accept_bit,
    input wire logic bcast_accept,
    input wire logic [CHAN_W-1:0] bcast_chan_sel,
    input wire logic mcast_accept,
    input wire logic [CHAN_W-1:0] mcast_chan_sel,
    input wire logic [CHAN_W-1:0] catchall_chan_sel,
    input wire logic accept_ctrl_frames,
    input wire logic accept_short_frames,
    input wire logic accept_error_frames,
    input wire logic accept_all_frames,
    input wire logic prio_filter_enable,
    input wire logic rx_keep_fcs,
    input wire logic [31:0] mcast_hash_lo,
    input wire logic [31:0] mcast_hash_hi,
    input wire logic [15:0] low_prio_drop_threshold,
    input wire logic max_len_wr,
    input wire logic [15:0] max_len_wdata,
    output logic [15:0] rx_max_frame_len,
    // station address programming
    input wire logic [CHAN_W-1:0] station_addr_index,
    input wire logic station_addr_upper_wr,
    input wire logic [31:0] station_addr_upper,
    input wire logic station_addr_lower_wr,
    input wire logic [15:0] station_addr_lower,
    // free buffer accounting
    input wire logic free_add_wr,
    input wire logic [CHAN_W-1:0] free_add_chan,
    input wire logic [15:0] free_add_count,
    input wire logic buf_used,
    input wire logic [CHAN_W-1:0] buf_used_chan,
    output logic [NUM_CHAN*CNT_W-1:0] rx_free_buf_count,
    // teardown and completion pointers
    input wire logic rx_chan_shutdown_cmd,
    input wire logic [CHAN_W-1:0] shutdown_chan_sel,
    output logic shutdown_done,
    output logic shutdown_done_flag,
    output logic [CHAN_W-1:0] shutdown_chan,
    output logic [NUM_CHAN-1:0] rx_irq,
    input wire logic comp_ptr_wr,
    input wire logic [CHAN_W-1:0] comp_ptr_chan,
    input wire logic [31:0] comp_ptr_wdata,
    input wire logic [CHAN_W-1:0] comp_ptr_rd_chan,
    output logic [31:0] rx_completion_ptr
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_CHAN-1:0] chan_en;
        logic [39:0] addr_upper;
        logic [NUM_CHAN-1:0][7:0] addr_low;
        logic [NUM_CHAN-1:0][CNT_W-1:0] free_cnt;
        logic [NUM_CHAN-1:0][31:0] comp_ptr;
        logic [NUM_CHAN-1:0] td_pend;
        logic [15:0] max_len;
        logic [15:0] byte_cnt;
        logic [47:0] da;
        logic [15:0] ltype;
        logic [15:0] tci;
        logic res_valid;
        logic res_accept;
        logic [CHAN_W-1:0] res_chan;
        frame_class_t res_class;
        logic [15:0] res_len;
        logic [15:0] res_frame_len;
        logic res_high_prio;
        logic res_is_bcast;
        logic pause;
        logic td_done;
        logic td_flag;
        logic [CHAN_W-1:0] td_chan;
        logic [NUM_CHAN-1:0] irq;
        logic [31:0] cp_rd;
    } st_t;

    st_t st_q, st_d;
    logic take, fifo_wr, fifo_rdy, errs, is_short, is_long, is_bcast, is_mcast, is_ctrl;
    logic hash_hit, addr_hit, uc_any, sta_any, qual_ok, low_prio, qos_drop, accept_now;
    logic [15:0] len_now;
    logic [CHAN_W-1:0] chan_now, uc_chan;
    logic [HASH_W-1:0] hash_idx;
    logic [NUM_CHAN-1:0] sta_hit;
    logic [NUM_CHAN-1:0][CNT_W-1:0] fc_next;
    logic [63:0] hash_tab;

    // six-bit fold of the destination address
    function automatic logic [HASH_W-1:0] hash_fold(input logic [47:0] a);
        logic [HASH_W-1:0] h;
        h = '0;
        for (int i = 0; i < 48 / HASH_W; i++) begin
            h = h ^ a[i*HASH_W +: HASH_W];
        end
        return h;
    endfunction

    // ------------------------------------------------------------
    // data buffering
    // ------------------------------------------------------------
    assign take = in_valid && in_ready;
    assign fifo_wr = in_valid && rx_dma_enable && (st_q.byte_cnt < st_q.max_len);

    rx_byte_fifo #(.WIDTH(BYTE_W), .DEPTH(DATA_FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wr_valid(fifo_wr),
        .wr_ready(fifo_rdy),
        .wr_data(in_data),
        .rd_valid(out_valid),
        .rd_ready(out_ready),
        .rd_data(out_data)
    );
    assign in_ready = fifo_rdy;

    // ------------------------------------------------------------
    // per-channel address match and free counts
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
        logic [CNT_W+1:0] sum;
        assign sta_hit[g] = (st_q.da[47:8] == st_q.addr_upper)
            && (st_q.da[7:0] == st_q.addr_low[g]);
        always_comb begin
            sum = {2'b00, st_q.free_cnt[g]};
            if (free_add_wr && free_add_chan == CHAN_W'(g)) begin
                sum = sum + {2'b00, free_add_count};
            end
            if (buf_used && buf_used_chan == CHAN_W'(g) && sum != '0) begin
                sum = sum - 1'b1;
            end
            fc_next[g] = (sum > {2'b00, CNT_SAT}) ? CNT_SAT : sum[CNT_W-1:0];
        end
    end

    always_comb begin
        uc_chan = '0;
        for (int k = NUM_CHAN - 1; k >= 0; k--) begin
            if (sta_hit[k] && st_q.chan_en[k]) begin
                uc_chan = CHAN_W'(k);
            end
        end
    end
    assign uc_any = |(sta_hit & st_q.chan_en);
    assign sta_any = |sta_hit;

    // ------------------------------------------------------------
    // frame verdict on the last byte
    // ------------------------------------------------------------
    assign len_now = (st_q.byte_cnt == CNT_SAT) ? CNT_SAT : st_q.byte_cnt + 16'h0001;
    assign errs = in_code_err || in_align_err || in_crc_err;
    assign is_short = len_now < MIN_FRAME_LEN;
    assign is_long = len_now > st_q.max_len;
    assign is_bcast = &st_q.da;
    assign is_mcast = st_q.da[GROUP_BIT] && !is_bcast;
    assign is_ctrl = st_q.ltype == CTRL_TYPE;
    assign hash_idx = hash_fold(st_q.da);
    assign hash_tab = {mcast_hash_hi, mcast_hash_lo};
    assign hash_hit = hash_tab[hash_idx];

    always_comb begin
        if (is_bcast) begin
            addr_hit = bcast_accept;
            chan_now = bcast_chan_sel;
        end else if (is_mcast) begin
            addr_hit = mcast_accept && hash_hit && st_q.chan_en[mcast_chan_sel];
            chan_now = mcast_chan_sel;
        end else begin
            addr_hit = uc_any;
            chan_now = uc_chan;
        end
        if (is_ctrl && !accept_ctrl_frames) begin
            addr_hit = 1'b0;
        end
        if (!addr_hit) begin
            chan_now = catchall_chan_sel;
        end
    end

    assign qual_ok = (!is_ctrl || accept_ctrl_frames)
        && ((!is_short && !is_long && !errs)
        || (is_short && accept_short_frames && (!errs || accept_error_frames))
        || (!is_short && (is_long || errs) && accept_error_frames));
    assign low_prio = !(st_q.ltype == VLAN_TYPE
        && st_q.tci[PRIO_MSB:PRIO_LSB] >= PRIO_HIGH_MIN);
    assign qos_drop = prio_filter_enable && low_prio
        && (st_q.free_cnt[chan_now] <= low_prio_drop_threshold);
    assign accept_now = rx_dma_enable && qual_ok && (addr_hit || accept_all_frames)
        && !qos_drop;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.res_valid = 1'b0;
        st_d.pause = 1'b0;
        st_d.td_done = 1'b0;
        st_d.td_flag = 1'b0;
        st_d.irq = '0;
        st_d.free_cnt = fc_next;
        st_d.cp_rd = st_q.comp_ptr[comp_ptr_rd_chan];
        st_d.chan_en = (st_q.chan_en & ~rx_chan_enable_clear) | rx_chan_enable_set;
        if (max_len_wr) begin
            st_d.max_len = max_len_wdata;
        end
        if (station_addr_upper_wr) begin
            st_d.addr_upper[39:8] = station_addr_upper;
        end
        if (station_addr_lower_wr) begin
            st_d.addr_upper[7:0] = station_addr_lower[15:8];
            st_d.addr_low[station_addr_index] = station_addr_lower[7:0];
        end
        if (comp_ptr_wr) begin
            st_d.comp_ptr[comp_ptr_chan] = comp_ptr_wdata;
        end
        if (take) begin
            if (st_q.byte_cnt < DA_BYTES) begin
                st_d.da = {st_q.da[39:0], in_data};
            end
            if (st_q.byte_cnt == TYPE_POS_HI || st_q.byte_cnt == TYPE_POS_LO) begin
                st_d.ltype = {st_q.ltype[7:0], in_data};
            end
            if (st_q.byte_cnt == TCI_POS_HI || st_q.byte_cnt == TCI_POS_LO) begin
                st_d.tci = {st_q.tci[7:0], in_data};
            end
            st_d.byte_cnt = len_now;
            if (in_last) begin
                st_d.byte_cnt = '0;
                st_d.res_valid = 1'b1;
                st_d.res_accept = accept_now;
                st_d.res_chan = chan_now;
                st_d.res_frame_len = len_now;
                st_d.res_high_prio = !low_prio;
                st_d.res_is_bcast = is_bcast;
                if (is_short) begin
                    st_d.res_class = errs ? CLS_FRAGMENT : CLS_UNDERSIZED;
                end else if (is_long) begin
                    st_d.res_class = errs ? CLS_JABBER : CLS_OVERSIZED;
                end else begin
                    st_d.res_class = errs ? CLS_ERRORED : CLS_PROPER;
                end
                if (is_long) begin
                    st_d.res_len = st_q.max_len;
                end else if (len_now <= RUNT_FCS_LEN || rx_keep_fcs) begin
                    st_d.res_len = len_now;
                end else begin
                    st_d.res_len = len_now - FCS_BYTES;
                end
                st_d.pause = is_ctrl && st_q.tci == PAUSE_OPCODE && !is_short && !is_long
                    && !errs && (st_q.da == PAUSE_DA || sta_any);
            end
        end
        // teardown runs only between frames
        if (st_q.byte_cnt == '0 && !take && st_q.td_pend != '0) begin
            for (int k = NUM_CHAN - 1; k >= 0; k--) begin
                if (st_q.td_pend[k]) begin
                    st_d.td_chan = CHAN_W'(k);
                end
            end
            st_d.td_done = 1'b1;
            st_d.td_pend[st_d.td_chan] = 1'b0;
            st_d.td_flag = st_q.chan_en[st_d.td_chan];
            st_d.irq[st_d.td_chan] = 1'b1;
            st_d.comp_ptr[st_d.td_chan] = TEARDOWN_PTR;
        end
        if (rx_chan_shutdown_cmd) begin
            st_d.td_pend[shutdown_chan_sel] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.max_len <= MAX_LEN_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign res_valid = st_q.res_valid;
    assign res_accept = st_q.res_accept;
    assign res_chan = st_q.res_chan;
    assign res_class = st_q.res_class;
    assign res_len = st_q.res_len;
    assign res_frame_len = st_q.res_frame_len;
    assign res_high_prio = st_q.res_high_prio;
    assign res_is_bcast = st_q.res_is_bcast;
    assign pause_detect = st_q.pause;
    assign chan_accept_bit = st_q.chan_en;
    assign rx_max_frame_len = st_q.max_len;
    assign rx_free_buf_count = st_q.free_cnt;
    assign shutdown_done = st_q.td_done;
    assign shutdown_done_flag = st_q.td_flag;
    assign shutdown_chan = st_q.td_chan;
    assign rx_irq = st_q.irq;
    assign rx_completion_ptr = st_q.cp_rd;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_bcast_one_chan;
        @(posedge ref_clk) disable iff (sys_rst)
        res_valid && res_accept && res_is_bcast && $past(bcast_accept)
            |-> res_chan == $past(bcast_chan_sel);
    endproperty
    a_bcast_one_chan: assert property (p_bcast_one_chan)
        else $error("broadcast steered to wrong channel");

    property p_bcast_off;
        @(posedge ref_clk) disable iff (sys_rst)
        res_valid && res_is_bcast && !$past(bcast_accept) && !$past(accept_all_frames)
            |-> !res_accept;
    endproperty
    a_bcast_off: assert property (p_bcast_off)
        else $error("broadcast accepted while disabled");

    property p_chan_set;
        @(posedge ref_clk) disable iff (sys_rst)
        rx_chan_enable_set != '0 |=> (chan_accept_bit & $past(rx_chan_enable_set))
            == $past(rx_chan_enable_set);
    endproperty
    a_chan_set: assert property (p_chan_set)
        else $error("channel enable set lost");

    property p_free_add;
        @(posedge ref_clk) disable iff (sys_rst)
        free_add_wr && !buf_used
            && 17'(st_q.free_cnt[free_add_chan]) + 17'(free_add_count) <= 17'(CNT_SAT)
            |=> st_q.free_cnt[$past(free_add_chan)]
                == $past(st_q.free_cnt[free_add_chan]) + $past(free_add_count);
    endproperty
    a_free_add: assert property (p_free_add)
        else $error("free count did not add host value");

    property p_td_done;
        @(posedge ref_clk) disable iff (sys_rst)
        shutdown_done |-> rx_irq[shutdown_chan]
            && st_q.comp_ptr[shutdown_chan] == TEARDOWN_PTR;
    endproperty
    a_td_done: assert property (p_td_done)
        else $error("teardown without interrupt or pointer");

    property p_td_keep_en;
        @(posedge ref_clk) disable iff (sys_rst)
        shutdown_done && $past(rx_chan_enable_set) == '0
            && $past(rx_chan_enable_clear) == '0 |-> $stable(chan_accept_bit);
    endproperty
    a_td_keep_en: assert property (p_td_keep_en)
        else $error("teardown changed channel enables");

    property p_td_wait;
        @(posedge ref_clk) disable iff (sys_rst)
        rx_chan_shutdown_cmd && st_q.byte_cnt == '0 && !take && st_q.td_pend == '0
            |=> ##1 shutdown_done && shutdown_chan == $past(shutdown_chan_sel, 2);
    endproperty
    a_td_wait: assert property (p_td_wait)
        else $error("idle teardown not completed in two cycles");

    property p_long_trunc;
        @(posedge ref_clk) disable iff (sys_rst)
        res_valid && (res_class == CLS_OVERSIZED || res_class == CLS_JABBER)
            |-> res_len == rx_max_frame_len;
    endproperty
    a_long_trunc: assert property (p_long_trunc)
        else $error("long frame length not max length");

    property p_runt_fcs;
        @(posedge ref_clk) disable iff (sys_rst)
        res_valid && res_frame_len <= RUNT_FCS_LEN |-> res_len == res_frame_len;
    endproperty
    a_runt_fcs: assert property (p_runt_fcs)
        else $error("short frame lost check bytes");

    property p_max_rst;
        @(posedge ref_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> rx_max_frame_len == MAX_LEN_RST;
    endproperty
    a_max_rst: assert property (p_max_rst)
        else $error("max length reset value wrong");
endmodule // rx_filter_steer
`default_nettype wire

// ---- tb/rx_host_model.sv ----
// dma drain side of the receive fifo, with a stall control
`timescale 1ns/1ps
`default_nettype none
module rx_host_model (
    // clock
    input wire logic ref_clk,
    // drain handshake and stall request
    output logic out_ready,
    input wire logic stall
);
    initial out_ready = '0;
    always @(negedge ref_clk) begin
        out_ready <= !stall;
    end
endmodule // rx_host_model
`default_nettype wire

// ---- tb/eth_rx_filter_channel_steer_tb.sv ----
// self-checking bench of the receive filter and steering block
`timescale 1ns/1ps
`default_nettype none
module eth_rx_filter_channel_steer_tb
    import rx_steer_pkg::*;
();
    // ----
    // signals
    // ----
    logic ref_clk = '0, sys_rst = '1, stall = '0, in_valid = '0, in_last = '0, in_code_err = '0;
    logic in_align_err = '0, in_crc_err = '0, rx_dma_enable = '0, bcast_accept = '0;
    logic mcast_accept = '0, accept_ctrl_frames = '0, accept_short_frames = '0, buf_used = '0;
    logic accept_error_frames = '0, accept_all_frames = '0, prio_filter_enable = '0;
    logic rx_keep_fcs = '0, max_len_wr = '0, station_addr_upper_wr = '0, free_add_wr = '0;
    logic station_addr_lower_wr = '0, rx_chan_shutdown_cmd = '0, comp_ptr_wr = '0;
    logic [2:0] bcast_chan_sel = '0, mcast_chan_sel = '0, catchall_chan_sel = '0;
    logic [2:0] station_addr_index = '0, free_add_chan = '0, buf_used_chan = '0;
    logic [2:0] shutdown_chan_sel = '0, comp_ptr_chan = '0, comp_ptr_rd_chan = '0;
    logic [7:0] in_data = '0, rx_chan_enable_set = '0, rx_chan_enable_clear = '0;
    logic [15:0] low_prio_drop_threshold = '0, max_len_wdata = '0, station_addr_lower = '0;
    logic [15:0] free_add_count = '0, ty = '0, tci = '0;
    logic [31:0] mcast_hash_lo = '0, mcast_hash_hi = '0, station_addr_upper = '0;
    logic [31:0] comp_ptr_wdata = '0, rx_completion_ptr;
    logic in_ready, out_valid, out_ready, res_valid, res_accept, res_high_prio, res_is_bcast;
    logic pause_detect, shutdown_done, shutdown_done_flag;
    logic [2:0] res_chan, shutdown_chan;
    logic [7:0] out_data, chan_accept_bit, rx_irq;
    logic [15:0] res_len, res_frame_len, rx_max_frame_len;
    logic [127:0] rx_free_buf_count;
    logic [47:0] da = '0;
    frame_class_t res_class;
    int errors = 0, n_checks = 0;
    rx_filter_steer DUT (.*);
    rx_host_model host (.*);
    always #2.5 ref_clk = ~ref_clk;
    task automatic chk(input logic [127:0] s, input logic [127:0] x);
        n_checks++;
        if (s !== x) begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, s, x);
        end
    endtask
    task automatic print_verdict();
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic frm(input int n, input logic [2:0] e, input logic a, input logic [2:0] c,
            input logic [15:0] l, input frame_class_t k);
        logic [127:0] h;
        h = {da, 48'h020a0b0c0d0e, ty, tci};
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            {in_valid, in_last} = {1'h1, i == n - 1};
            in_data = (i < 16) ? h[127 - 8 * i -: 8] : i[7:0];
            {in_code_err, in_align_err, in_crc_err} = in_last ? e : 3'h0;
            while (in_ready !== 1'b1)
                @(negedge ref_clk);
        end
        @(negedge ref_clk);
        {in_valid, in_last} = '0;
        chk({res_valid, res_accept, res_class, res_frame_len}, {1'h1, a, k, n[15:0]});
        if (a)
            chk({res_chan, res_len}, {c, l});
    endtask
    initial begin
        repeat (4) @(negedge ref_clk);
        sys_rst = '0;
        chk(rx_max_frame_len, 16'h05ee);
        {station_addr_index, station_addr_upper_wr, station_addr_upper} = {4'h3, 32'h02112233};
        @(negedge ref_clk);
        {station_addr_upper_wr, station_addr_lower_wr, station_addr_lower} = {2'h1, 16'h4401};
        @(negedge ref_clk);
        rx_dma_enable = '1;
        {station_addr_lower_wr, rx_chan_enable_set, rx_chan_enable_clear} = {1'h0, 16'h0202};
        @(negedge ref_clk);
        {rx_chan_enable_set, rx_chan_enable_clear} = '0;
        chk(chan_accept_bit, 8'h02);
        {da, ty, stall} = {48'h021122334401, 16'h0800, 1'h1};
        fork
            begin
                repeat (40) @(negedge ref_clk);
                chk({in_ready, out_valid, out_data}, 10'h102);
                stall = '0;
            end
        join_none
        frm(64, 0, 1, 1, 60, CLS_PROPER);
        accept_short_frames = '1;
        frm(20, 0, 1, 1, 20, CLS_UNDERSIZED);
        frm(30, 3'h4, 0, 0, 0, CLS_FRAGMENT);
        {max_len_wr, max_len_wdata, accept_error_frames} = 18'h200c9;
        @(negedge ref_clk);
        max_len_wr = '0;
        frm(103, 0, 1, 1, 100, CLS_OVERSIZED);
        frm(104, 3'h1, 1, 1, 100, CLS_JABBER);
        {free_add_wr, free_add_chan, free_add_count} = {4'h9, 16'h0001};
        @(negedge ref_clk);
        free_add_wr = '0;
        {prio_filter_enable, low_prio_drop_threshold, ty, tci} = {17'h10001, 32'h81008000};
        frm(64, 0, 1, 1, 60, CLS_PROPER);
        chk(res_high_prio, 1);
        tci = 16'h6000;
        frm(64, 0, 0, 0, 0, CLS_PROPER);
        {prio_filter_enable, ty, tci} = 33'h008000000;
        {bcast_accept, bcast_chan_sel, da} = {4'hd, 48'hffffffffffff};
        frm(64, 0, 1, 5, 60, CLS_PROPER);
        chk(res_is_bcast, 1);
        {mcast_accept, mcast_chan_sel, mcast_hash_lo, da} = {4'h9, 32'h4000, 48'h01005e000001};
        frm(64, 0, 1, 1, 60, CLS_PROPER);
        {accept_all_frames, catchall_chan_sel, rx_keep_fcs, da} = {5'h1d, 48'h021122334499};
        frm(64, 0, 1, 6, 64, CLS_PROPER);
        {ty, tci, da} = {32'h88080001, 48'h021122334400};
        frm(64, 0, 0, 0, 0, CLS_PROPER);
        chk(pause_detect, 1);
        {free_add_wr, free_add_chan, free_add_count} = {4'ha, 16'h0005};
        @(negedge ref_clk);
        {free_add_wr, buf_used, buf_used_chan} = 5'h0a;
        chk(rx_free_buf_count[47:32], 16'h0005);
        @(negedge ref_clk);
        {buf_used, free_add_wr, free_add_count} = {2'h1, 16'hffff};
        chk(rx_free_buf_count[47:32], 16'h0004);
        @(negedge ref_clk);
        free_add_wr = '0;
        chk(rx_free_buf_count[47:32], 16'hffff);
        for (int j = 0; j < 2; j++) begin
            {rx_chan_shutdown_cmd, shutdown_chan_sel, comp_ptr_rd_chan} = {1'h1, j ? 6'h09 : 6'h1b};
            @(negedge ref_clk);
            rx_chan_shutdown_cmd = '0;
            @(negedge ref_clk);
            chk({shutdown_done, shutdown_done_flag, rx_irq}, {1'h1, j[0], 8'h1 << (j ? 1 : 3)});
            chk(shutdown_chan, j ? 1 : 3);
            repeat (2) @(negedge ref_clk);
            chk(rx_completion_ptr, 32'hfffffffc);
            chk(chan_accept_bit, 8'h02);
        end
        chk(out_valid, 0);
        print_verdict();
    end
    initial begin
        #100000;
        errors++;
        print_verdict();
    end
endmodule // eth_rx_filter_channel_steer_tb
`default_nettype wire
